// ===== ccpd_top.sv
// clock and sync-reference power-down control registers and gating
// assumes a simple synchronous register port on clk_i, one byte wide
`timescale 1ns/100ps
`default_nettype none
`include "ccpd_defs.svh"
module ccpd_top
  import ccpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`CCPD_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic sync_ref_i,
  output logic [7:0] reg_rdata_o,
  output logic pair_a_clk_en_o,
  output logic pair_b_clk_en_o,
  output logic serial_pll_ref_en_o,
  output logic clock_receiver_en_o,
  output logic sync_receiver_en_o,
  output logic sync_hysteresis_en_o,
  output logic sync_align_pulse_o
);
  ccpd_req_t req;
  ccpd_ctrl_t ctrl;
  logic [7:0] clkcfg_r;
  logic [7:0] sync_r;
  logic [7:0] rdata_r;
  logic pa_en_r;
  logic pb_en_r;
  logic spll_en_r;
  logic crec_en_r;
  logic srec_en_r;
  logic hys_r;
  logic pulse_w;

  // request bundle and address decode
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};
  wire logic sel_clk = req.addr == `CCPD_OFS_CLKCFG;
  wire logic sel_sync = req.addr == `CCPD_OFS_SYNC;
  // write masks keep reserved bits at zero
  wire logic [7:0] clkcfg_nxt = (req.wr && sel_clk) ?
    (req.wdata & `CCPD_CLKCFG_WMASK) : clkcfg_r;
  wire logic [7:0] sync_nxt = (req.wr && sel_sync) ?
    (req.wdata & `CCPD_SYNC_WMASK) : sync_r;
  // unmapped addresses read zero; data holds until the next read so
  // software may pick it up at leisure
  wire logic [7:0] rdata_nxt = !req.rd ? rdata_r :
    sel_clk ? clkcfg_r : sel_sync ? sync_r : 8'h00;

  // field view of the two registers
  assign ctrl.pair_a_clock_powerdown = clkcfg_r[`CCPD_BIT_PAIR_A];
  assign ctrl.pair_b_clock_powerdown = clkcfg_r[`CCPD_BIT_PAIR_B];
  assign ctrl.all_converter_clock_powerdown = clkcfg_r[`CCPD_BIT_ALL];
  assign ctrl.serial_pll_ref_powerdown = clkcfg_r[`CCPD_BIT_SPLL];
  assign ctrl.clock_receiver_powerdown = clkcfg_r[`CCPD_BIT_CREC];
  assign ctrl.sync_receiver_powerdown = sync_r[`CCPD_BIT_SYNC_PD];
  assign ctrl.sync_hysteresis_enable = sync_r[`CCPD_BIT_HYS];
  assign ctrl.sync_sample_edge_select = sync_r[`CCPD_BIT_EDGE];

  // a dead clock receiver starves the pairs and the serial PLL reference, so it gates them too
  // pair A enable
  wire logic pa_en_nxt = ~ctrl.pair_a_clock_powerdown &
    ~ctrl.all_converter_clock_powerdown & ~ctrl.clock_receiver_powerdown;
  // pair B enable; global gate applies to both
  wire logic pb_en_nxt = ~ctrl.pair_b_clock_powerdown &
    ~ctrl.all_converter_clock_powerdown & ~ctrl.clock_receiver_powerdown;
  wire logic spll_en_nxt = ~ctrl.serial_pll_ref_powerdown &
    ~ctrl.clock_receiver_powerdown;
  wire logic crec_en_nxt = ~ctrl.clock_receiver_powerdown;
  wire logic srec_en_nxt = ~ctrl.sync_receiver_powerdown;

  // registers, reset to documented power-down defaults
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clkcfg_r <= `CCPD_CLKCFG_RST;
      sync_r <= `CCPD_SYNC_RST;
      rdata_r <= 8'h00;
    end
    else
    begin
      clkcfg_r <= clkcfg_nxt;
      sync_r <= sync_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // enables registered so every output comes from a flop; the extra
  // cycle of latency is traded for glitch-free gate controls
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pa_en_r <= 1'b0;
      pb_en_r <= 1'b0;
      spll_en_r <= 1'b0;
      crec_en_r <= 1'b0;
      srec_en_r <= 1'b0;
      hys_r <= 1'b0;
    end
    else
    begin
      pa_en_r <= pa_en_nxt;
      pb_en_r <= pb_en_nxt;
      spll_en_r <= spll_en_nxt;
      crec_en_r <= crec_en_nxt;
      srec_en_r <= srec_en_nxt;
      hys_r <= ctrl.sync_hysteresis_enable;
    end
  end

  // no alignment once the sync receiver has been off for a cycle
  ccpd_sync_sampler u_sampler (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sync_i(sync_ref_i),
    .enable_i(srec_en_r),
    .rise_sel_i(ctrl.sync_sample_edge_select),
    .pulse_o(pulse_w)
  );

  assign reg_rdata_o = rdata_r;
  assign pair_a_clk_en_o = pa_en_r;
  assign pair_b_clk_en_o = pb_en_r;
  assign serial_pll_ref_en_o = spll_en_r;
  assign clock_receiver_en_o = crec_en_r;
  assign sync_receiver_en_o = srec_en_r;
  assign sync_hysteresis_en_o = hys_r;
  assign sync_align_pulse_o = pulse_w;

  // checks assert only on what the design drives, reading inputs as triggers; the bench owns the inputs
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // pair gating: off while a power-down bit is set, on once all are clear
  a_pair_a_off: assert property (
    clkcfg_r[`CCPD_BIT_PAIR_A] |=> !pair_a_clk_en_o)
    else $error("pair A clock runs while powered down");
  a_pair_a_on: assert property (
    !clkcfg_r[`CCPD_BIT_PAIR_A] && !clkcfg_r[`CCPD_BIT_ALL] &&
    !clkcfg_r[`CCPD_BIT_CREC] |=> pair_a_clk_en_o)
    else $error("pair A clock stays off after power-up");
  a_pair_b_off: assert property (
    clkcfg_r[`CCPD_BIT_PAIR_B] |=> !pair_b_clk_en_o)
    else $error("pair B clock runs while powered down");
  a_pair_b_on: assert property (
    !clkcfg_r[`CCPD_BIT_PAIR_B] && !clkcfg_r[`CCPD_BIT_ALL] &&
    !clkcfg_r[`CCPD_BIT_CREC] |=> pair_b_clk_en_o)
    else $error("pair B clock stays off after power-up");
  a_global_gate: assert property (clkcfg_r[`CCPD_BIT_ALL] |=>
    !pair_a_clk_en_o && !pair_b_clk_en_o)
    else $error("global gate ignored");
  a_spll_ref_cut: assert property (req.wr && sel_clk &&
    req.wdata[`CCPD_BIT_SPLL] |=> ##1 !serial_pll_ref_en_o)
    else $error("serial PLL reference not withheld");
  a_spll_ref_on: assert property (
    !clkcfg_r[`CCPD_BIT_SPLL] && !clkcfg_r[`CCPD_BIT_CREC] |=>
    serial_pll_ref_en_o)
    else $error("serial PLL reference not passed");

  // a powered-down receiver passes no clock anywhere
  a_clk_rx_off: assert property (clkcfg_r[`CCPD_BIT_CREC] |=>
    !clock_receiver_en_o && !pair_a_clk_en_o)
    else $error("clock receiver on while powered down");
  a_clk_rx_gates: assert property (clkcfg_r[`CCPD_BIT_CREC] |=>
    !serial_pll_ref_en_o && !pair_b_clk_en_o)
    else $error("clock passed with receiver powered down");

  // sync receiver power follows its bit both ways
  a_sync_rx_on: assert property (req.wr && sel_sync &&
    !req.wdata[`CCPD_BIT_SYNC_PD] |=> ##1 sync_receiver_en_o)
    else $error("sync receiver not enabled");
  a_sync_rx_off: assert property (
    sync_r[`CCPD_BIT_SYNC_PD] |=> !sync_receiver_en_o)
    else $error("sync receiver powered while bit set");
  a_hys_follow: assert property (sync_hysteresis_en_o ==
    $past(sync_r[`CCPD_BIT_HYS]))
    else $error("hysteresis enable mismatch");

  // the pulse flop reads the enable of the cycle before it
  a_no_pulse_off: assert property (
    !srec_en_r |=> !sync_align_pulse_o)
    else $error("alignment pulse while receiver off");
  // one edge kind per select value, so pulses never come back to back while the select holds
  a_pulse_single: assert property (
    sync_align_pulse_o && $stable(sync_r[`CCPD_BIT_EDGE]) |=>
    !sync_align_pulse_o)
    else $error("alignment pulse longer than one cycle");

  // register side: reserved bits, refused writes, read data
  a_reserved_zero: assert property (
    (clkcfg_r & ~`CCPD_CLKCFG_WMASK) == 8'h00 &&
    (sync_r & ~`CCPD_SYNC_WMASK) == 8'h00)
    else $error("reserved bit set");
  a_write_refused: assert property (
    req.wr && !sel_clk && !sel_sync |=> $stable(clkcfg_r) && $stable(sync_r))
    else $error("write to unmapped address changed a register");
  a_read_back: assert property (req.rd && sel_clk |=>
    reg_rdata_o == $past(clkcfg_r))
    else $error("clock register read data wrong");
  a_rdata_hold: assert property (!req.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  c_pair_a_on: cover property (pair_a_clk_en_o);
  c_pair_b_on: cover property (pair_b_clk_en_o);
  c_spll_on: cover property (serial_pll_ref_en_o);
  c_sync_pulse: cover property (sync_align_pulse_o);
  c_rise_pulse: cover property (sync_align_pulse_o && sync_r[`CCPD_BIT_EDGE]);
endmodule // ccpd_top
`default_nettype wire

// ===== ccpd_defs.svh
// constants for the clock and sync power-down control block
// assumes inclusion by bare name from every design file of the block
`ifndef CCPD_DEFS_SVH
`define CCPD_DEFS_SVH
`define CCPD_ADDR_W 12
`define CCPD_OFS_CLKCFG 12'h080
`define CCPD_OFS_SYNC 12'h081
`define CCPD_BIT_PAIR_A 7
`define CCPD_BIT_PAIR_B 6
`define CCPD_BIT_ALL 5
`define CCPD_BIT_SPLL 4
`define CCPD_BIT_CREC 3
`define CCPD_BIT_SYNC_PD 4
`define CCPD_BIT_HYS 3
`define CCPD_BIT_EDGE 2
`define CCPD_CLKCFG_RST 8'hf8
`define CCPD_SYNC_RST 8'h10
`define CCPD_CLKCFG_WMASK 8'hf8
`define CCPD_SYNC_WMASK 8'h1c
`define CCPD_SYNC_STAGES 2
`endif

// ===== ccpd_pkg.sv
// types shared by the clock and sync power-down control block
// assumes ccpd_defs.svh is on the include path
`include "ccpd_defs.svh"
package ccpd_pkg;
  // register read or write request from the documented register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`CCPD_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } ccpd_req_t;
  // decoded power-down and sync controls
  typedef struct packed {
    logic pair_a_clock_powerdown;
    logic pair_b_clock_powerdown;
    logic all_converter_clock_powerdown;
    logic serial_pll_ref_powerdown;
    logic clock_receiver_powerdown;
    logic sync_receiver_powerdown;
    logic sync_hysteresis_enable;
    logic sync_sample_edge_select;
  } ccpd_ctrl_t;
endpackage : ccpd_pkg

// ===== ccpd_sync_sampler.sv
// sync reference sampler: two-flop synchroniser, then edge choice
// assumes sync_i is asynchronous to clk_i and comes from the receiver
`timescale 1ns/100ps
`default_nettype none
`include "ccpd_defs.svh"
module ccpd_sync_sampler
  import ccpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sync_i,
  input wire logic enable_i,
  input wire logic rise_sel_i,
  output logic pulse_o
);
  logic [`CCPD_SYNC_STAGES-1:0] sync_r;
  logic last_r;
  logic pulse_r;
  wire logic sync_s = sync_r[`CCPD_SYNC_STAGES-1];
  wire logic rise_w = sync_s & ~last_r;
  wire logic fall_w = ~sync_s & last_r;
  wire logic pulse_nxt = enable_i & (rise_sel_i ? rise_w : fall_w);
  // first stage only feeds the second; edges use the synced copy
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync_r <= '0;
      last_r <= 1'b0;
      pulse_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[`CCPD_SYNC_STAGES-2:0], sync_i};
      last_r <= sync_s;
      pulse_r <= pulse_nxt;
    end
  end
  assign pulse_o = pulse_r;
endmodule // ccpd_sync_sampler
`default_nettype wire

// ===== test_ccpd_top.sv
// self-checking bench for the clock and sync power-down registers
// assumes the design files and ccpd_defs.svh are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "ccpd_defs.svh"
module test_ccpd_top
  import ccpd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic sref = 1'b0;
  logic [7:0] rdata;
  logic [5:0] en;
  logic pulse;
  int miscompares = 0;
  int check_count = 0;
  int n;
  logic [7:0] cv [7] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'hff};
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  ccpd_top ccpd_top_i
  (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .sync_ref_i(sref),
    .reg_rdata_o(rdata),
    .pair_a_clk_en_o(en[5]),
    .pair_b_clk_en_o(en[4]),
    .serial_pll_ref_en_o(en[3]),
    .clock_receiver_en_o(en[2]),
    .sync_receiver_en_o(en[1]),
    .sync_hysteresis_en_o(en[0]),
    .sync_align_pulse_o(pulse)
  );
  // enables expected from both register values; clock receiver off stops both pairs and the PLL reference
  function automatic logic [7:0] expen(input logic [7:0] c,
                                       input logic [7:0] s);
    return {2'b00, !(c[7] | c[5] | c[3]), !(c[6] | c[5] | c[3]),
      !(c[4] | c[3]), !c[3], !s[4], s[3]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one strobe cycle, then one cycle so the registered enables have landed; read data lands at the end of the strobe
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clk_i);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  // drive the sync level and count alignment pulses over eight cycles
  task automatic edge_cnt(input logic lvl, input logic [7:0] exp);
    n = 0;
    sref = lvl;
    repeat (8)
    begin
      @(posedge clk_i);
      #1;
      n += (pulse === 1'b1);
    end
    chk("align_pulses", 8'(n), exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog so a stuck run still reaches the verdict
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    chk("enables_reset", {2'b00, en}, 8'h00);
    // a write to an unmapped address must leave both registers alone
    acc(1'b1, 12'h082, 8'hff);
    acc(1'b0, `CCPD_OFS_CLKCFG, 8'h00);
    chk("clkcfg_reset", rdata, 8'hf8);
    acc(1'b0, `CCPD_OFS_SYNC, 8'h00);
    chk("sync_reset", rdata, 8'h10);
    acc(1'b0, 12'h082, 8'h00);
    chk("unmapped_read", rdata, 8'h00);
    $display("done: reset values");
    acc(1'b1, `CCPD_OFS_SYNC, 8'hff);
    acc(1'b0, `CCPD_OFS_SYNC, 8'h00);
    chk("sync_reserved", rdata, 8'h1c);
    acc(1'b1, `CCPD_OFS_SYNC, 8'h08);
    // walk each clock power-down bit alone, then all together
    foreach (cv[i])
    begin
      acc(1'b1, `CCPD_OFS_CLKCFG, cv[i]);
      chk("enables", {2'b00, en}, expen(cv[i], 8'h08));
      acc(1'b0, `CCPD_OFS_CLKCFG, 8'h00);
      chk("clkcfg_read", rdata, cv[i] & 8'hf8);
    end
    $display("done: clock power-down");
    // clock register is left at 0xf8 by the last walk step
    // each sample edge choice sees only its own sync transition
    for (int e = 0; e < 2; e++)
    begin
      acc(1'b1, `CCPD_OFS_SYNC, e ? 8'h04 : 8'h00);
      chk("sync_enables", {2'b00, en}, expen(8'hf8, e ? 8'h04 : 8'h00));
      edge_cnt(1'b1, e ? 8'h01 : 8'h00);
      edge_cnt(1'b0, e ? 8'h00 : 8'h01);
    end
    acc(1'b1, `CCPD_OFS_SYNC, 8'h14);
    chk("sync_off", {2'b00, en}, expen(8'hf8, 8'h14));
    edge_cnt(1'b1, 8'h00);
    edge_cnt(1'b0, 8'h00);
    $display("done: sync receiver");
    end_of_test();
  end
endmodule // test_ccpd_top
`default_nettype wire
